// [rtl/disk_if_pkg.sv]
package disk_if_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int ACK_DELAY_NS  = 2000;
    localparam int ACK_PULSE_NS  = 5000;
    localparam int READ_PULSE_NS = 160;
    localparam int CNT_W         = 8;

    // Least times round up to whole cycles
    localparam logic [CNT_W-1:0] ACK_DELAY_CYC =
        CNT_W'((ACK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ACK_PULSE_CYC =
        CNT_W'((ACK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] READ_PULSE_CYC =
        CNT_W'((READ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // ****************************************************************
    // Track and selection
    // ****************************************************************
    localparam int TRACK_W  = 8;
    localparam int SEL_W    = 4;
    localparam int SWITCH_W = 3;
    localparam logic [TRACK_W-1:0] MAX_TRACK  = 8'hca;
    localparam logic [TRACK_W-1:0] TRACK_ZERO = 8'h00;
    localparam logic [SWITCH_W-1:0] LAST_LINEAR_POS = 3'h3;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic powerOk;
        logic cartLoaded;
        logic doorClosed;
        logic runSwitch;
        logic atSpeed;
        logic headsLoaded;
        logic writeFault;
    } driveStatus_t;

    typedef struct packed {
        logic                controller_type_line;
        logic [SEL_W-1:0]    selectLines;
        logic [SWITCH_W-1:0] switchPos;
        logic [TRACK_W-1:0]  cylAddr;
        logic                strobe;
        logic                go_track_zero;
        logic                headSelect;
        logic                writeInhibit;
        logic                writeGate;
        logic                readGate;
        logic                write_lock_button;
        logic                writeLink;
        driveStatus_t        status;
    } pinBundle_t;

    localparam pinBundle_t PINS_RESET = '0;

endpackage

// [rtl/stream_fifo.sv]
`timescale 1ns/1ps
module stream_fifo
    import disk_if_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter int DEPTH = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_B = $clog2(DEPTH + 1);
    localparam logic [CNT_B-1:0] FULL_CNT = CNT_B'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr_reg;
    logic [PTR_W-1:0] rdPtr_reg;
    logic [CNT_B-1:0] count_reg;
    logic [CNT_B-1:0] count_next;
    logic             notFull_reg;
    logic             outValid_reg;
    logic [WIDTH-1:0] outData_reg;

    // Handshake decode
    wire doWrite = inValid && notFull_reg;
    wire doLoad  = (count_reg != '0) && (!outValid_reg || outReady);
    assign count_next = count_reg + CNT_B'(doWrite) - CNT_B'(doLoad);

    // Storage and pointers
    always_ff @(posedge sys_clk) begin
        if (doWrite) begin
            mem[wrPtr_reg] <= inData;
        end
        if (sys_rst) begin
            wrPtr_reg   <= '0;
            rdPtr_reg   <= '0;
            count_reg   <= '0;
            notFull_reg <= 1'b1;
        end else begin
            if (doWrite) begin
                wrPtr_reg <= (wrPtr_reg == LAST_PTR) ? '0 : wrPtr_reg + 1'b1;
            end
            if (doLoad) begin
                rdPtr_reg <= (rdPtr_reg == LAST_PTR) ? '0 : rdPtr_reg + 1'b1;
            end
            count_reg   <= count_next;
            notFull_reg <= (count_next != FULL_CNT);
        end
    end

    // Registered read stage
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            outValid_reg <= 1'b0;
            outData_reg  <= '0;
        end else if (doLoad) begin
            outValid_reg <= 1'b1;
            outData_reg  <= mem[rdPtr_reg];
        end else if (outReady) begin
            outValid_reg <= 1'b0;
        end
    end

    assign inReady  = notFull_reg;
    assign outValid = outValid_reg;
    assign outData  = outData_reg;

endmodule

// [rtl/disk_drive_host_interface.sv]
`timescale 1ns/1ps
// Contract
// - Controller-type line picks linear or binary select
// - Linear: switch 0-3 chooses one high line
// - Binary: 3-bit number must match switch
// - Track codes 0 to 202 are valid
// - Head select high upper, low lower
// - Inhibit-write input sets write protect
// - Write-lock button toggles write protect
// - Power-up and load-to-run clear protect
// - Write gate turns on write and erase
// - Zero-return: accept, clear track, go zero
// - Read outputs driven only while read-enabled
// - Operational needs all seven conditions true
// - Idle-ready: operational and no seek running
// - Valid seek: 5 us accept, 2 us after
// - Track above 202: reject pulse, no move
module disk_drive_host_interface
    import disk_if_pkg::*;
#(
    parameter int DATA_W     = 1,
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire pinBundle_t        pinsIn,
    input  wire logic              headBitValid,
    input  wire logic [DATA_W-1:0] headBit,
    input  wire logic              seekDone,
    output logic                   headBitReady,
    output logic                   acceptN,
    output logic                   rejectN,
    output logic     [TRACK_W-1:0] targetTrack,
    output logic                   seekStart,
    output logic                   moveToZero,
    output logic                   upperHead,
    output logic                   writeProtect,
    output logic                   writeCurrentOn,
    output logic                   eraseCurrentOn,
    output logic                   writeHeadPulse,
    output logic                   readClockOut,
    output logic      [DATA_W-1:0] readDataOut,
    output logic                   operational,
    output logic                   idleReady
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    pinBundle_t pinS1_reg;
    pinBundle_t pinS2_reg;
    pinBundle_t pinS3_reg;

    // Two flops per pin, third only for edge finding
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pinS1_reg <= PINS_RESET;
            pinS2_reg <= PINS_RESET;
            pinS3_reg <= PINS_RESET;
        end else begin
            pinS1_reg <= pinsIn;
            pinS2_reg <= pinS1_reg;
            pinS3_reg <= pinS2_reg;
        end
    end

    // ****************************************************************
    // Drive selection
    // ****************************************************************
    wire [SWITCH_W-1:0] swPos      = pinS2_reg.switchPos;
    wire                linearMode = !pinS2_reg.controller_type_line;
    wire                linearSel  = (swPos <= LAST_LINEAR_POS) &&
                                     pinS2_reg.selectLines[swPos[1:0]];
    wire                binarySel  =
        (pinS2_reg.selectLines[SWITCH_W-1:0] == swPos);
    wire                selected   = linearMode ? linearSel : binarySel;

    // ****************************************************************
    // Status decode
    // ****************************************************************
    wire driveStatus_t st = pinS2_reg.status;
    wire opNow = st.powerOk && st.cartLoaded && st.doorClosed &&
                 st.runSwitch && st.atSpeed && st.headsLoaded &&
                 !st.writeFault;

    // ****************************************************************
    // Seek handshake
    // ****************************************************************
    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_PULSE, S_HOLD} seekState_t;

    seekState_t          state_reg;
    logic [CNT_W-1:0]    cnt_reg;
    logic                rtz_reg;
    logic                valid_reg;
    logic [TRACK_W-1:0]  cyl_reg;
    logic [TRACK_W-1:0]  track_reg;
    logic                acceptN_reg;
    logic                rejectN_reg;
    logic                seekStart_reg;
    logic                moveZero_reg;
    logic                busy_reg;

    wire strobeRise = pinS2_reg.strobe && !pinS3_reg.strobe;
    wire takeCmd    = (state_reg == S_IDLE) && strobeRise && selected;
    wire cylValid   = (pinS2_reg.cylAddr <= MAX_TRACK);
    wire waitDone   = (state_reg == S_WAIT) && (cnt_reg == ACK_DELAY_CYC);
    wire pulseDone  = (state_reg == S_PULSE) && (cnt_reg == ACK_PULSE_CYC);
    wire goMove     = waitDone && (rtz_reg || valid_reg);

    // Sequencer state and cycle counter
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= S_IDLE;
            cnt_reg   <= CNT_ZERO;
        end else begin
            unique case (state_reg)
                S_IDLE: begin
                    if (takeCmd) begin
                        state_reg <= S_WAIT;
                        cnt_reg   <= CNT_ONE;
                    end
                end
                S_WAIT: begin
                    cnt_reg <= waitDone ? CNT_ONE : cnt_reg + CNT_ONE;
                    if (waitDone) begin
                        state_reg <= S_PULSE;
                    end
                end
                S_PULSE: begin
                    cnt_reg <= cnt_reg + CNT_ONE;
                    if (pulseDone) begin
                        state_reg <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    if (!pinS2_reg.strobe) begin
                        state_reg <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // Latch command at strobe
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rtz_reg   <= 1'b0;
            valid_reg <= 1'b0;
            cyl_reg   <= TRACK_ZERO;
        end else if (takeCmd) begin
            rtz_reg   <= pinS2_reg.go_track_zero;
            valid_reg <= cylValid;
            cyl_reg   <= pinS2_reg.cylAddr;
        end
    end

    // Answer pulses, active low
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            acceptN_reg <= 1'b1;
            rejectN_reg <= 1'b1;
        end else if (waitDone) begin
            acceptN_reg <= !(rtz_reg || valid_reg);
            rejectN_reg <= rtz_reg || valid_reg;
        end else if (pulseDone) begin
            acceptN_reg <= 1'b1;
            rejectN_reg <= 1'b1;
        end
    end

    // Track register and positioner commands
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            track_reg     <= TRACK_ZERO;
            seekStart_reg <= 1'b0;
            moveZero_reg  <= 1'b0;
        end else begin
            seekStart_reg <= goMove && !rtz_reg;
            moveZero_reg  <= goMove && rtz_reg;
            if (goMove) begin
                track_reg <= rtz_reg ? TRACK_ZERO : cyl_reg;
            end
        end
    end

    // Seek in progress until positioner reports done
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            busy_reg <= 1'b0;
        end else if (goMove) begin
            busy_reg <= 1'b1;
        end else if (seekDone) begin
            busy_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Write path and protect
    // ****************************************************************
    logic protect_reg;
    logic upper_reg;
    logic wrCur_reg;
    logic wrPulse_reg;
    logic op_reg;
    logic idle_reg;

    wire buttonRise = pinS2_reg.write_lock_button &&
                      !pinS3_reg.write_lock_button;
    wire runRise    = st.runSwitch && !pinS3_reg.status.runSwitch;
    wire linkRise   = pinS2_reg.writeLink && !pinS3_reg.writeLink;
    wire writeOk    = selected && pinS2_reg.writeGate && !protect_reg;

    // Protect flop: set wins over toggle and clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            protect_reg <= 1'b0;
        end else if (pinS2_reg.writeInhibit) begin
            protect_reg <= 1'b1;
        end else if (buttonRise) begin
            protect_reg <= !protect_reg;
        end else if (runRise) begin
            protect_reg <= 1'b0;
        end
    end

    // Head choice, write current, link edges, status
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            upper_reg   <= 1'b0;
            wrCur_reg   <= 1'b0;
            wrPulse_reg <= 1'b0;
            op_reg      <= 1'b0;
            idle_reg    <= 1'b0;
        end else begin
            upper_reg   <= pinS2_reg.headSelect;
            wrCur_reg   <= writeOk;
            wrPulse_reg <= writeOk && linkRise;
            op_reg      <= opNow;
            idle_reg    <= opNow && !busy_reg && !goMove;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic              fifoValid;
    logic [DATA_W-1:0] fifoData;
    logic              rdActive_reg;
    logic              rdClk_reg;
    logic [DATA_W-1:0] rdData_reg;
    logic [CNT_W-1:0]  rdCnt_reg;

    wire readOn  = selected && pinS2_reg.readGate;
    wire rdTake  = readOn && !rdActive_reg && fifoValid;
    wire rdPhase = rdActive_reg && (rdCnt_reg == READ_PULSE_CYC);

    stream_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .inValid  (headBitValid),
        .inReady  (headBitReady),
        .inData   (headBit),
        .outValid (fifoValid),
        .outReady (rdTake),
        .outData  (fifoData)
    );

    // One clock pulse per bit, then a gap one cycle longer
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !readOn) begin
            rdActive_reg <= 1'b0;
            rdClk_reg    <= 1'b0;
            rdData_reg   <= '0;
            rdCnt_reg    <= CNT_ZERO;
        end else if (rdTake) begin
            rdActive_reg <= 1'b1;
            rdClk_reg    <= 1'b1;
            rdData_reg   <= fifoData;
            rdCnt_reg    <= CNT_ONE;
        end else if (rdPhase) begin
            rdActive_reg <= rdClk_reg;
            rdClk_reg    <= 1'b0;
            rdData_reg   <= '0;
            rdCnt_reg    <= CNT_ONE;
        end else if (rdActive_reg) begin
            rdCnt_reg <= rdCnt_reg + CNT_ONE;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign acceptN        = acceptN_reg;
    assign rejectN        = rejectN_reg;
    assign targetTrack    = track_reg;
    assign seekStart      = seekStart_reg;
    assign moveToZero     = moveZero_reg;
    assign upperHead      = upper_reg;
    assign writeProtect   = protect_reg;
    assign writeCurrentOn = wrCur_reg;
    assign eraseCurrentOn = wrCur_reg;
    assign writeHeadPulse = wrPulse_reg;
    assign readClockOut   = rdClk_reg;
    assign readDataOut    = rdData_reg;
    assign operational    = op_reg;
    assign idleReady      = idle_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    logic [CNT_W-1:0] lowCnt_reg;

    // Length of current accept pulse
    always_ff @(posedge sys_clk) begin
        if (sys_rst || acceptN_reg) begin
            lowCnt_reg <= CNT_ZERO;
        end else begin
            lowCnt_reg <= lowCnt_reg + CNT_ONE;
        end
    end

    sequence acceptStarts;
        !acceptN_reg && rejectN_reg;
    endsequence

    sequence rejectStarts;
        !rejectN_reg && acceptN_reg && !seekStart_reg && !moveZero_reg
        ##1 !seekStart_reg && !moveZero_reg;
    endsequence

    AST_ACCEPT_TIME: assert property (takeCmd && cylValid |-> ##51 acceptStarts)
        else $error("accept pulse not 2 us after strobe");
    AST_REJECT_TIME: assert property (takeCmd && !cylValid &&
        !pinS2_reg.go_track_zero |-> ##51 rejectStarts)
        else $error("reject pulse missing or heads moved");
    AST_PULSE_WIDTH: assert property ($rose(acceptN_reg) |->
        lowCnt_reg == 8'h7d)
        else $error("accept pulse not 5 us wide");
    AST_ZERO_RETURN: assert property (takeCmd && pinS2_reg.go_track_zero
        |-> ##51 !acceptN_reg && moveZero_reg &&
        track_reg == TRACK_ZERO)
        else $error("zero return not carried out");
    AST_IGNORE_UNSEL: assert property (state_reg == S_IDLE && !selected
        |=> state_reg == S_IDLE)
        else $error("unselected drive took a command");
    AST_LINEAR_SEL: assert property (linearMode &&
        swPos > LAST_LINEAR_POS |-> !selected)
        else $error("linear mode selected on high switch");
    AST_INHIBIT_SET: assert property (pinS2_reg.writeInhibit
        |=> protect_reg ##1 !wrCur_reg)
        else $error("inhibit did not protect");
    AST_WRITE_GATE: assert property (wrCur_reg |->
        $past(pinS2_reg.writeGate) && eraseCurrentOn)
        else $error("write current without gate");
    AST_READ_GATE: assert property (rdClk_reg |-> $past(readOn))
        else $error("read clock without read enable");
    AST_IDLE_READY: assert property (idle_reg |-> op_reg && !busy_reg)
        else $error("idle ready while not operational");

endmodule

// [tb/disk_ctrl_model.sv]
`timescale 1ns/1ps
module disk_ctrl_model
    import disk_if_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire pinBundle_t         cfgIn,
    input  wire logic               seekReq,
    input  wire logic [TRACK_W-1:0] seekCyl,
    input  wire logic               seekZero,
    input  wire logic               acceptN,
    input  wire logic               rejectN,
    output pinBundle_t              pinsOut
);
    logic               busReg  = 1'b0;
    logic               stbReg  = 1'b0;
    logic               doneReg = 1'b0;
    logic               rtzReg  = 1'b0;
    logic               linkClk = 1'b0;
    logic [TRACK_W-1:0] cylReg  = 8'h00;
    int                 gateCnt = 0;

    // ****************************************************************
    // Seek handshake
    // ****************************************************************
    // Address settles a cycle before strobe; released bus toggles
    always @(posedge sys_clk) begin
        busReg  <= seekReq;
        cylReg  <= seekReq ? seekCyl : ~cylReg;
        rtzReg  <= seekReq ? seekZero : ~rtzReg;
        doneReg <= seekReq && (doneReg || !acceptN || !rejectN);
        stbReg  <= seekReq && busReg && !doneReg && acceptN && rejectN;
    end

    // ****************************************************************
    // Write link
    // ****************************************************************
    // Link clock runs, but the line only moves while gated
    always #160 linkClk = ~linkClk;

    // Data held back 1 us after the gate rises
    always @(posedge sys_clk) begin
        if (!cfgIn.writeGate) gateCnt <= 0;
        else if (gateCnt < 25) gateCnt <= gateCnt + 1;
    end

    // Controller owns strobe, address, zero-return and link
    always_comb begin
        pinsOut               = cfgIn;
        pinsOut.strobe        = stbReg;
        pinsOut.cylAddr       = cylReg;
        pinsOut.go_track_zero = rtzReg;
        pinsOut.writeLink     = cfgIn.writeGate && (gateCnt >= 25) &&
                                linkClk;
    end
endmodule

// [tb/disk_drive_host_interface_bench.sv]
`timescale 1ns/1ps
module disk_drive_host_interface_bench
    import disk_if_pkg::*;
;
    logic       sys_clk = 1'b0;
    logic       sys_rst = 1'b1;
    pinBundle_t cfg     = PINS_RESET;
    pinBundle_t pins;
    logic       seekReq = 1'b0, seekZero = 1'b0, seekDone = 1'b0;
    logic [7:0] seekCyl = 8'h00;
    logic       headBitValid = 1'b0;
    logic [0:0] headBit = 1'b0;
    logic       headBitReady, acceptN, rejectN, seekStart, moveToZero;
    logic       upperHead, writeProtect, writeCurrentOn, eraseCurrentOn;
    logic       writeHeadPulse, readClockOut, operational, idleReady;
    logic [7:0] targetTrack;
    logic [0:0] readDataOut;
    int         mismatches = 0, total_checks = 0, cycles = 0, n, m, p, q;

    always #20 sys_clk = ~sys_clk;

    disk_ctrl_model disk_ctrl_model_i (.sys_clk(sys_clk), .cfgIn(cfg),
        .seekReq(seekReq), .seekCyl(seekCyl), .seekZero(seekZero),
        .acceptN(acceptN), .rejectN(rejectN), .pinsOut(pins));

    disk_drive_host_interface disk_drive_host_interface_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .pinsIn(pins),
        .headBitValid(headBitValid), .headBit(headBit),
        .seekDone(seekDone), .headBitReady(headBitReady),
        .acceptN(acceptN), .rejectN(rejectN), .targetTrack(targetTrack),
        .seekStart(seekStart), .moveToZero(moveToZero),
        .upperHead(upperHead), .writeProtect(writeProtect),
        .writeCurrentOn(writeCurrentOn), .eraseCurrentOn(eraseCurrentOn),
        .writeHeadPulse(writeHeadPulse), .readClockOut(readClockOut),
        .readDataOut(readDataOut), .operational(operational),
        .idleReady(idleReady));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic wait_cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask

    // Seek: strobe-to-answer count, then pulse width
    task automatic seek(input logic [7:0] cyl, input logic zero,
                        input logic acc, input logic rej);
        @(posedge sys_clk);
        seekReq <= 1'b1; seekCyl <= cyl; seekZero <= zero;
        n = 0;
        do @(negedge sys_clk); while (pins.strobe !== 1'b1 && ++n < 10);
        n = 0;
        while (acceptN === 1'b1 && rejectN === 1'b1 && n < 300) begin
            @(negedge sys_clk); n++;
        end
        check(n, (acc || rej) ? 16'd53 : 16'd300);
        check({acceptN, rejectN}, {!acc, !rej});
        m = 0; p = 0; q = 0;
        while ((acceptN === 1'b0 || rejectN === 1'b0) && m < 300) begin
            if (seekStart === 1'b1) p++;
            if (moveToZero === 1'b1) q++;
            @(negedge sys_clk); m++;
        end
        if (acc || rej) check(m, 16'd125);
        check(p, acc && !zero);
        check(q, acc && zero);
        @(posedge sys_clk) seekReq <= 1'b0;
        wait_cyc(6);
    endtask

    task automatic finish_seek();
        @(posedge sys_clk) seekDone <= 1'b1;
        @(posedge sys_clk) seekDone <= 1'b0;
        wait_cyc(6);
    endtask

    // Gate the writer for 65 cycles and count head pulses
    task automatic write_burst(input logic on);
        @(posedge sys_clk) cfg.writeGate <= 1'b1;
        p = 0;
        repeat (65) begin
            @(negedge sys_clk);
            if (writeHeadPulse === 1'b1) p++;
        end
        check({writeCurrentOn, eraseCurrentOn}, {on, on});
        check(on ? (p > 3 && p < 7) : (p != 0), on);
        @(posedge sys_clk) cfg.writeGate <= 1'b0;
        wait_cyc(6);
    endtask

    task automatic push(input logic b);
        @(posedge sys_clk);
        headBitValid <= 1'b1; headBit <= b;
        @(posedge sys_clk) headBitValid <= 1'b0;
    endtask

    task automatic pin_pulse(input int which);
        @(posedge sys_clk);
        if (which == 0) cfg.writeInhibit <= 1'b1;
        else if (which == 1) cfg.write_lock_button <= 1'b1;
        else cfg.status.runSwitch <= 1'b0;
        wait_cyc(4);
        @(posedge sys_clk);
        if (which == 0) cfg.writeInhibit <= 1'b0;
        else if (which == 1) cfg.write_lock_button <= 1'b0;
        else cfg.status.runSwitch <= 1'b1;
        wait_cyc(6);
    endtask

    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        check({acceptN, rejectN, writeProtect, headBitReady}, 4'hd);
        check(targetTrack, 8'h00);
        cfg.status <= 7'b1111110; cfg.selectLines <= 4'h2;
        cfg.switchPos <= 3'h1; cfg.headSelect <= 1'b1;
        wait_cyc(6);
        check({operational, idleReady, upperHead}, 3'h7);
        seek(8'hca, 1'b0, 1'b1, 1'b0);
        check({targetTrack, idleReady}, {8'hca, 1'b0});
        finish_seek();
        check(idleReady, 1'b1);
        seek(8'hcb, 1'b0, 1'b0, 1'b1);
        check(targetTrack, 8'hca);
        seek(8'hcb, 1'b1, 1'b1, 1'b0);
        check(targetTrack, 8'h00);
        finish_seek();
        cfg.selectLines <= 4'h1;
        seek(8'h05, 1'b0, 1'b0, 1'b0);
        cfg.controller_type_line <= 1'b1;
        cfg.switchPos <= 3'h5; cfg.selectLines <= 4'hd;
        seek(8'h07, 1'b0, 1'b1, 1'b0);
        check(targetTrack, 8'h07);
        finish_seek();
        cfg.selectLines <= 4'h4;
        seek(8'h09, 1'b0, 1'b0, 1'b0);
        cfg.selectLines <= 4'h5;
        cfg.status.writeFault <= 1'b1;
        cfg.headSelect <= 1'b0;
        wait_cyc(6);
        check({operational, idleReady, upperHead}, 3'h0);
        cfg.status.writeFault <= 1'b0;
        write_burst(1'b1);
        pin_pulse(0);
        check(writeProtect, 1'b1);
        write_burst(1'b0);
        pin_pulse(1);
        check(writeProtect, 1'b0);
        pin_pulse(1);
        check(writeProtect, 1'b1);
        pin_pulse(2);
        check(writeProtect, 1'b0);
        for (int i = 0; i < 5; i++) push(5'b11011 >> i);
        wait_cyc(4);
        check({headBitReady, readClockOut}, 2'h0);
        cfg.readGate <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            n = 0;
            do @(negedge sys_clk); while (readClockOut !== 1'b1 && ++n < 40);
            check(readDataOut, (5'b11011 >> i) & 5'h01);
            do @(negedge sys_clk); while (readClockOut === 1'b1 && ++n < 40);
        end
        check(headBitReady, 1'b1);
        summarize();
    end
endmodule
